// ===== rtl/pass_pkg.sv
// Shared offsets, field positions and reset values for the shift/store pair datapath
package pass_pkg;
   // Register byte offsets (paddr[11:0])
   localparam logic [11:0] PASS_OFF_CTRL   = 12'h000; // Go strobe, saturation mode
   localparam logic [11:0] PASS_OFF_OPER   = 12'h004; // Operand selectors
   localparam logic [11:0] PASS_OFF_SBASE  = 12'h008; // Shift source base address
   localparam logic [11:0] PASS_OFF_DBASE  = 12'h00C; // Store destination base address
   localparam logic [11:0] PASS_OFF_IDXA   = 12'h010; // index_register_a
   localparam logic [11:0] PASS_OFF_IDXB   = 12'h014; // index_register_b
   localparam logic [11:0] PASS_OFF_FLAGS  = 12'h018; // Condition flags
   localparam logic [11:0] PASS_OFF_ISTAT  = 12'h01C; // Sticky event status, read only
   localparam logic [11:0] PASS_OFF_ICLR   = 12'h020; // Event clear, write only
   localparam logic [11:0] PASS_OFF_IEN    = 12'h024; // Event enable
   localparam logic [11:0] PASS_OFF_RBASE  = 12'h040; // Working registers 0..7
   localparam logic [1:0]  PASS_MEM_SEL    = 2'h1;    // paddr[11:10] for memory window
   // Control fields
   localparam int PASS_CTRL_GO  = 0; // Write 1 starts one execute cycle
   localparam int PASS_CTRL_SAT = 1; // saturation_mode_bit
   // Operand selector fields
   localparam int PASS_OP_CNT   = 0;  // Count register, 4 bits
   localparam int PASS_OP_DST1  = 4;  // Shift destination register, 4 bits
   localparam int PASS_OP_SRC3  = 8;  // Store source register, 4 bits
   localparam int PASS_OP_SDISP = 12; // Shift source displacement select, 2 bits
   localparam int PASS_OP_DDISP = 14; // Store destination displacement select, 2 bits
   // Flag bit positions
   localparam int PASS_F_C   = 0;
   localparam int PASS_F_V   = 1;
   localparam int PASS_F_Z   = 2;
   localparam int PASS_F_N   = 3;
   localparam int PASS_F_UF  = 4;
   localparam int PASS_F_LV  = 5;
   localparam int PASS_F_LUF = 6;
   // Event bit positions
   localparam int PASS_EV_DONE = 0; // Execute cycle finished
   localparam int PASS_EV_OVF  = 1; // Integer overflow in the shift
   localparam int PASS_EV_ILL  = 2; // Go refused: register number above 7
   localparam int PASS_EV_W    = 3;
   // Reset values
   localparam logic [6:0]  PASS_FLAGS_RST = 7'h00;
   localparam logic [15:0] PASS_OPER_RST  = 16'h0000;
   localparam logic [31:0] PASS_WORD_RST  = 32'h0000_0000;
   // Shift limits
   localparam int PASS_SHIFT_MAX = 32; // Largest shift in either direction
   localparam int PASS_NREG      = 8;  // Working registers
   // Displacement selector codes
   typedef enum logic [1:0] {
      PASS_DISP_ZERO = 2'b00,
      PASS_DISP_ONE  = 2'b01,
      PASS_DISP_IDXA = 2'b10,
      PASS_DISP_IDXB = 2'b11
   } pass_disp_t;
endpackage

// ===== rtl/pass_shifter.sv
// Combinational arithmetic shifter with carry and overflow
`timescale 1ns/1ps
module pass_shifter
   import pass_pkg::*;
(
   input  wire logic [31:0] src,      // Operand from memory
   input  wire logic [6:0]  count,    // Signed count, low seven bits
   output logic      [31:0] result,   // Shifted value
   output logic             carry,    // Last bit shifted out
   output logic             ovf       // Integer overflow
);
   logic signed [6:0]  cnt_s;   // Count as signed value
   logic        [6:0]  mag;     // Magnitude, clamped
   logic        [63:0] wide;    // Sign-extended work word
   logic signed [63:0] wide_s;  // Signed view for right shift

   // Shift amount and direction
   always_comb begin
      cnt_s  = count; // see [RQ1] see [RQ7]
      mag    = cnt_s[6] ? 7'(-cnt_s) : count;
      // Magnitudes beyond the documented range saturate at the maximum
      if (mag > 7'(PASS_SHIFT_MAX)) begin
         mag = 7'(PASS_SHIFT_MAX);
      end
      wide   = 64'h0000_0000_0000_0000;
      wide_s = 64'sh0000_0000_0000_0000;
      result = src;
      carry  = 1'b0;
      ovf    = 1'b0;
      if (mag == 7'h00) begin
         result = src; // see [RQ4]
         carry  = 1'b0; // see [RQ4]
      end else if (!cnt_s[6]) begin
         // Left: zeros in at the bottom, out through carry at the top
         wide   = {{32{src[31]}}, src} << mag; // see [RQ2]
         result = wide[31:0];
         carry  = wide[32]; // see [RQ12]
         // Overflow when the upper part no longer matches the sign
         ovf    = !((&wide[63:31]) || !(|wide[63:31])); // see [RQ11]
      end else begin
         // Right: sign copies in at the top, out through carry at the bottom
         wide_s = $signed({src, 32'h0000_0000}) >>> mag; // see [RQ3]
         result = wide_s[63:32];
         carry  = wide_s[31]; // see [RQ12]
      end
   end
endmodule

// ===== rtl/pass_mem.sv
// Data memory with two read ports and one write port
`timescale 1ns/1ps
module pass_mem
   import pass_pkg::*;
#(
   parameter int ADDR_W = 8  // Word address width
)(
   input  wire logic              pclk,     // Clock
   input  wire logic [ADDR_W-1:0] ra_addr,  // Shift operand read address
   output logic      [31:0]       ra_data,  // Shift operand read data
   input  wire logic [ADDR_W-1:0] rb_addr,  // Bus read address
   output logic      [31:0]       rb_data,  // Bus read data
   input  wire logic              we,       // Write enable
   input  wire logic [ADDR_W-1:0] waddr,    // Write address
   input  wire logic [31:0]       wdata     // Write data
);
   logic [31:0] mem [2**ADDR_W]; // Storage, no reset

   // Reads see the contents before this edge's write
   always_comb begin
      ra_data = mem[ra_addr]; // see [RQ6]
      rb_data = mem[rb_addr];
   end

   // Write at the clock edge that ends the cycle
   always_ff @(posedge pclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end
endmodule

// ===== rtl/pass_top.sv
// APB-controlled shift-and-store parallel execute datapath
// Notes on behaviour
// [RQ1] Count is low seven bits, signed, up to 32
// [RQ2] Positive count: left shift, zero fill, carry out
// [RQ3] Negative count: right shift, sign fill, carry out
// [RQ4] Zero count: pass unshifted, carry cleared
// [RQ5] Registers read at start, written at end
// [RQ6] Shift source read before store writes memory
// [RQ7] Count and destination are signed integers
// [RQ8] Flags change only for destination registers 0-7
// [RQ9] Sticky underflow kept; sticky overflow sets on overflow
// [RQ10] Underflow cleared, negative is MSB, zero flag
// [RQ11] Overflow flag follows integer overflow
// [RQ12] Carry takes last bit shifted out
// [RQ13] Saturation mode bit never changes the result
// [RQ14] Registers 0-7 only; indirect displacement 0,1,indices
// [RQ15] Store source register written to store address
`timescale 1ns/1ps
module pass_top
   import pass_pkg::*;
#(
   parameter int ADDR_W = 8  // Data memory word address width
)(
   input  wire logic        pclk,     // Clock, 100 MHz
   input  wire logic        presetn,  // Asynchronous reset, active low
   input  wire logic        psel,     // APB select
   input  wire logic        penable,  // APB enable
   input  wire logic        pwrite,   // APB direction
   input  wire logic [11:0] paddr,    // APB byte address
   input  wire logic [31:0] pwdata,   // APB write data
   output logic      [31:0] prdata,   // APB read data
   output logic             pready,   // APB ready
   output logic             pslverr,  // APB error, unmapped address
   output logic             irq       // Level interrupt
);
   // State
   logic [31:0]       rf_reg    [PASS_NREG]; // Working registers
   logic [31:0]       rf_next   [PASS_NREG];
   logic [15:0]       oper_reg;               // Operand selectors
   logic [15:0]       oper_next;
   logic [31:0]       sbase_reg, sbase_next;  // Shift source base
   logic [31:0]       dbase_reg, dbase_next;  // Store destination base
   logic [31:0]       idxa_reg, idxa_next;    // index_register_a
   logic [31:0]       idxb_reg, idxb_next;    // index_register_b
   logic [6:0]        flags_reg, flags_next;  // Condition flags
   logic              sat_reg, sat_next;      // saturation_mode_bit, stored only
   logic              exec_reg, exec_next;    // Execute cycle in progress
   logic              execd_reg, execd_next;  // Execute happened last cycle
   logic [PASS_EV_W-1:0] stat_reg, stat_next; // Sticky events
   logic [PASS_EV_W-1:0] ien_reg, ien_next;   // Event enables
   logic [31:0]       rdata_reg, rdata_next;  // Registered read data

   // Decoded operands
   logic [3:0]        cnt_sel, dst1_sel, src3_sel; // Register numbers
   pass_disp_t        sdisp, ddisp;                // Displacement selects
   logic [31:0]       saddr, daddr;                // Effective addresses
   logic [31:0]       mem_op;                      // Shift operand from memory
   logic [31:0]       mem_rd;                      // Bus read from memory
   logic [31:0]       sh_res;                      // Shift result
   logic              sh_c, sh_v;                  // Shift carry and overflow
   logic [31:0]       pwd;                          // Write data, unmasked copy of pwdata
   logic              acc, wr, rd_en;               // Bus phases
   logic              is_mem, is_rf, mapped;        // Address decode
   logic [2:0]        rf_idx;                       // Bus register index
   logic              oper_ok;                      // All register numbers legal
   logic              mem_we;                       // Memory write strobe
   logic [ADDR_W-1:0] mem_wa;                       // Memory write address
   logic [31:0]       mem_wd;                       // Memory write data

   // Displacement per select code
   function automatic logic [31:0] disp_of(input pass_disp_t sel,
                                           input logic [31:0] ia,
                                           input logic [31:0] ib);
      logic [31:0] d;
      d = 32'h0000_0000;
      unique case (sel)
         PASS_DISP_ZERO: d = 32'h0000_0000;
         PASS_DISP_ONE:  d = 32'h0000_0001;
         PASS_DISP_IDXA: d = ia;
         PASS_DISP_IDXB: d = ib;
      endcase
      return d;
   endfunction

   // Operand decode and effective addresses
   always_comb begin
      cnt_sel  = oper_reg[PASS_OP_CNT +: 4];
      dst1_sel = oper_reg[PASS_OP_DST1 +: 4];
      src3_sel = oper_reg[PASS_OP_SRC3 +: 4];
      sdisp    = pass_disp_t'(oper_reg[PASS_OP_SDISP +: 2]);
      ddisp    = pass_disp_t'(oper_reg[PASS_OP_DDISP +: 2]);
      // Indirect with displacement 0, 1 or an index register
      saddr    = sbase_reg + disp_of(sdisp, idxa_reg, idxb_reg); // see [RQ14]
      daddr    = dbase_reg + disp_of(ddisp, idxa_reg, idxb_reg); // see [RQ14]
      // Register numbers above 7 are refused at go
      oper_ok  = !cnt_sel[3] && !dst1_sel[3] && !src3_sel[3]; // see [RQ14]
   end

   // Shifter sees only the operand and count; mode bit is not routed in
   pass_shifter u_shift (
      .src    (mem_op),
      .count  (rf_reg[cnt_sel[2:0]][6:0]), // see [RQ1] see [RQ13]
      .result (sh_res),
      .carry  (sh_c),
      .ovf    (sh_v)
   );

   // Memory: execute store has the write port during its cycle
   always_comb begin
      mem_we = 1'b0;
      mem_wa = paddr[ADDR_W+1:2];
      mem_wd = pwdata;
      if (exec_reg) begin
         // Store source value before any shift write lands
         mem_we = 1'b1; // see [RQ15]
         mem_wa = daddr[ADDR_W-1:0];
         mem_wd = rf_reg[src3_sel[2:0]]; // see [RQ5]
      end else if (wr && is_mem) begin
         mem_we = 1'b1;
      end
   end

   pass_mem #(.ADDR_W(ADDR_W)) u_mem (
      .pclk    (pclk),
      .ra_addr (saddr[ADDR_W-1:0]),
      .ra_data (mem_op),
      .rb_addr (paddr[ADDR_W+1:2]),
      .rb_data (mem_rd),
      .we      (mem_we),
      .waddr   (mem_wa),
      .wdata   (mem_wd)
   );

   // Bus decode; stall while an execute cycle is pending or just done
   always_comb begin
      pready  = !exec_reg && !execd_reg;
      acc     = psel && penable && pready;
      wr      = acc && pwrite;
      rd_en   = psel && !pwrite;
      pwd     = pwdata;
      is_mem  = (paddr[11:10] == PASS_MEM_SEL) && (paddr[9:2] < 8'(2**ADDR_W - 1))
                || (paddr[11:10] == PASS_MEM_SEL) && (paddr[9:2] == 8'(2**ADDR_W - 1));
      is_rf   = (paddr[11:5] == PASS_OFF_RBASE[11:5]);
      rf_idx  = paddr[4:2];
      unique case (paddr)
         PASS_OFF_CTRL, PASS_OFF_OPER, PASS_OFF_SBASE, PASS_OFF_DBASE,
         PASS_OFF_IDXA, PASS_OFF_IDXB, PASS_OFF_FLAGS, PASS_OFF_ISTAT,
         PASS_OFF_ICLR, PASS_OFF_IEN: mapped = 1'b1;
         default:                     mapped = is_rf || is_mem;
      endcase
      pslverr = psel && penable && pready && !mapped;
      prdata  = rdata_reg;
      irq     = |(stat_reg & ien_reg);
   end

   // Next state: bus writes, execute cycle, flags, events
   always_comb begin
      logic [PASS_EV_W-1:0] ev;  // Events this cycle
      logic [PASS_EV_W-1:0] clr; // Clears this cycle
      ev         = '0;
      clr        = '0;
      rf_next    = rf_reg;
      oper_next  = oper_reg;
      sbase_next = sbase_reg;
      dbase_next = dbase_reg;
      idxa_next  = idxa_reg;
      idxb_next  = idxb_reg;
      flags_next = flags_reg;
      sat_next   = sat_reg;
      ien_next   = ien_reg;
      exec_next  = 1'b0;
      execd_next = exec_reg;
      rdata_next = rdata_reg;
      // Bus writes; none can land during execute since pready is low
      if (wr && mapped) begin
         unique case (paddr)
            PASS_OFF_CTRL: begin
               sat_next = pwd[PASS_CTRL_SAT];
               if (pwd[PASS_CTRL_GO]) begin
                  // Illegal register numbers refuse the go
                  exec_next = oper_ok; // see [RQ14]
                  ev[PASS_EV_ILL] = !oper_ok;
               end
            end
            PASS_OFF_OPER:  oper_next  = pwd[15:0];
            PASS_OFF_SBASE: sbase_next = pwd;
            PASS_OFF_DBASE: dbase_next = pwd;
            PASS_OFF_IDXA:  idxa_next  = pwd;
            PASS_OFF_IDXB:  idxb_next  = pwd;
            PASS_OFF_FLAGS: flags_next = pwd[6:0];
            PASS_OFF_ICLR:  clr        = pwd[PASS_EV_W-1:0];
            PASS_OFF_IEN:   ien_next   = pwd[PASS_EV_W-1:0];
            default: begin
               if (is_rf) begin
                  rf_next[rf_idx] = pwd;
               end
            end
         endcase
      end
      // Execute cycle: all inputs from current registers, results at this edge
      if (exec_reg) begin
         rf_next[dst1_sel[2:0]] = sh_res; // see [RQ5]
         ev[PASS_EV_DONE] = 1'b1;
         ev[PASS_EV_OVF]  = sh_v;
         // Destination is always one of registers 0-7 once accepted
         if (!dst1_sel[3]) begin // see [RQ8]
            flags_next[PASS_F_C]  = sh_c; // see [RQ12]
            flags_next[PASS_F_V]  = sh_v; // see [RQ11]
            flags_next[PASS_F_Z]  = (sh_res == 32'h0000_0000); // see [RQ10]
            flags_next[PASS_F_N]  = sh_res[31]; // see [RQ10]
            flags_next[PASS_F_UF] = 1'b0; // see [RQ10]
            flags_next[PASS_F_LV] = flags_reg[PASS_F_LV] | sh_v; // see [RQ9]
            flags_next[PASS_F_LUF] = flags_reg[PASS_F_LUF]; // see [RQ9]
         end
      end
      // Set wins over a clear in the same cycle
      stat_next = (stat_reg & ~clr) | ev;
      // Read data captured every cycle the slave is selected for a read
      if (rd_en) begin
         if (is_mem) begin
            rdata_next = mem_rd;
         end else if (is_rf) begin
            rdata_next = rf_reg[rf_idx];
         end else begin
            unique case (paddr)
               PASS_OFF_CTRL:  rdata_next = {30'h0000_0000, sat_reg, 1'b0};
               PASS_OFF_OPER:  rdata_next = {16'h0000, oper_reg};
               PASS_OFF_SBASE: rdata_next = sbase_reg;
               PASS_OFF_DBASE: rdata_next = dbase_reg;
               PASS_OFF_IDXA:  rdata_next = idxa_reg;
               PASS_OFF_IDXB:  rdata_next = idxb_reg;
               PASS_OFF_FLAGS: rdata_next = {25'h000_0000, flags_reg};
               PASS_OFF_ISTAT: rdata_next = {29'h0000_0000, stat_reg};
               PASS_OFF_IEN:   rdata_next = {29'h0000_0000, ien_reg};
               default:        rdata_next = 32'h0000_0000;
            endcase
         end
      end
   end

   // Register everything
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < PASS_NREG; i++) begin
            rf_reg[i] <= PASS_WORD_RST;
         end
         oper_reg  <= PASS_OPER_RST;
         sbase_reg <= PASS_WORD_RST;
         dbase_reg <= PASS_WORD_RST;
         idxa_reg  <= PASS_WORD_RST;
         idxb_reg  <= PASS_WORD_RST;
         flags_reg <= PASS_FLAGS_RST;
         sat_reg   <= 1'b0;
         exec_reg  <= 1'b0;
         execd_reg <= 1'b0;
         stat_reg  <= '0;
         ien_reg   <= '0;
         rdata_reg <= PASS_WORD_RST;
      end else begin
         rf_reg    <= rf_next;
         oper_reg  <= oper_next;
         sbase_reg <= sbase_next;
         dbase_reg <= dbase_next;
         idxa_reg  <= idxa_next;
         idxb_reg  <= idxb_next;
         flags_reg <= flags_next;
         sat_reg   <= sat_next;
         exec_reg  <= exec_next;
         execd_reg <= execd_next;
         stat_reg  <= stat_next;
         ien_reg   <= ien_next;
         rdata_reg <= rdata_next;
      end
   end
endmodule

// ===== sim/pass_top_assertions.sv
// Port-level checker for the shift/store pair datapath
`timescale 1ns/1ps
module pass_chk
   import pass_pkg::*;
(
   input wire logic        pclk,     // Clock
   input wire logic        presetn,  // Reset, active low
   input wire logic        psel,     // APB select
   input wire logic        penable,  // APB enable
   input wire logic        pwrite,   // APB direction
   input wire logic [11:0] paddr,    // APB address
   input wire logic [31:0] pwdata,   // APB write data
   input wire logic [31:0] prdata,   // APB read data
   input wire logic        pready,   // APB ready
   input wire logic        pslverr,  // APB error
   input wire logic        irq       // Interrupt
);
   logic        acc;     // Completing access
   logic        go_w;    // Go strobe taken
   logic        go_ok;   // Go with legal registers
   logic [15:0] oper_q;  // Shadow of operand selectors
   logic        ien_q;   // Shadow of done enable
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   assign acc = psel && penable && pready;
   assign go_w = acc && pwrite && paddr == PASS_OFF_CTRL && pwdata[PASS_CTRL_GO];
   // Refusal hinges on bit3 of each register field
   assign go_ok = go_w && !(oper_q[3] || oper_q[7] || oper_q[11]);
   // Shadows track what software wrote
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oper_q <= 16'h0000;
         ien_q  <= 1'b0;
      end else if (acc && pwrite && paddr == PASS_OFF_OPER) begin
         oper_q <= pwdata[15:0];
      end else if (acc && pwrite && paddr == PASS_OFF_IEN) begin
         ien_q <= pwdata[PASS_EV_DONE];
      end
   end
   go_stall_a: assert property (go_ok |=> !pready ##1 !pready ##1 pready)
      else $error("bad go stall");
   bad_go_a: assert property (go_w && !go_ok |=> pready)
      else $error("refused go still stalled");
   done_irq_a: assert property (go_ok && ien_q |-> ##2 irq)
      else $error("done interrupt late");
   err_phase_a: assert property (pslverr |-> acc)
      else $error("error outside access phase");
   gap_err_a: assert property (acc && paddr inside {[12'h028:12'h03C]} |-> pslverr)
      else $error("gap address accepted");
   unmap_rd_a: assert property (acc && pslverr && !pwrite |-> prdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   clr_rd_a: assert property (acc && !pwrite && paddr == PASS_OFF_ICLR
      |-> prdata == 32'h0000_0000 && !pslverr)
      else $error("clear register read wrong");
   go_rd_a: assert property (acc && !pwrite && paddr == PASS_OFF_CTRL |-> !prdata[0])
      else $error("go bit reads back");
   mask_irq_a: assert property (acc && pwrite && paddr == PASS_OFF_IEN && pwdata[2:0] == 3'h0
      |=> !irq)
      else $error("masked interrupt high");
   clr_irq_a: assert property (acc && pwrite && paddr == PASS_OFF_ICLR && pwdata[2:0] == 3'h7
      |=> !irq)
      else $error("cleared interrupt high");
   go_c: cover property (go_ok);
   ill_c: cover property (go_w && !go_ok);
   err_c: cover property (pslverr);
   irq_c: cover property ($rose(irq));
endmodule
bind pass_top pass_chk pass_chk_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

// ===== sim/tb.sv
// Self-checking bench for the shift/store pair datapath
`timescale 1ns/1ps
module tb
   import pass_pkg::*;
;
   logic        pclk = 1'b0;           // Clock
   logic        presetn = 1'b0;        // Reset, active low
   logic        psel = 1'b0;           // APB select
   logic        penable = 1'b0;        // APB enable
   logic        pwrite = 1'b0;         // APB direction
   logic [11:0] paddr = 12'h000;       // APB address
   logic [31:0] pwdata = 32'h0000_0000; // APB write data
   logic [31:0] prdata;                // APB read data
   logic        pready;                // APB ready
   logic        pslverr;               // APB error
   logic        irq;                   // Interrupt
   logic [31:0] rd_q;                  // Last read data
   logic        rd_e;                  // Last error
   int          err_total = 0;         // Mismatches
   int          n_compared = 0;        // Comparisons
   int          cycles = 0;            // Timeout count
   pass_top pass_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq));
   // Free-running 100 MHz clock
   initial begin
      forever #5 pclk = ~pclk;
   end
   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Hang guard, far above the expected run
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         give_verdict();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   // One APB transfer, held until pready is high at a rising edge
   task automatic apb(input logic [11:0] a, input logic [31:0] d, input logic w = 1'b1);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd_q = prdata;
      rd_e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a);
      apb(a, 32'h0, 1'b0);
   endtask
   // Second falling edge: a status set by an execute has landed
   task automatic chk_irq(input logic exp);
      repeat (2) @(negedge pclk);
      chk({31'h0, irq}, {31'h0, exp}, "irq");
   endtask
   // Model shift: {ovf, carry, result}, clamped at 32
   function automatic logic [33:0] ref_sh(logic [31:0] s, logic [6:0] c);
      int          n;
      logic [63:0] w;
      n = $signed(c);
      n = (n > 32) ? 32 : (n < -32) ? -32 : n;
      if (n == 0) return {2'b00, s};
      if (n > 0) begin
         w = {{32{s[31]}}, s} << n;
         return {w[63:31] != {33{w[31]}}, s[32-n], w[31:0]};
      end
      w = {{32{s[31]}}, s} >> (-n);
      return {1'b0, s[-n-1], w[31:0]};
   endfunction
   task automatic t_reset();
      logic [11:0] a [7] = '{PASS_OFF_OPER, PASS_OFF_SBASE, PASS_OFF_FLAGS, PASS_OFF_ISTAT,
                             PASS_OFF_IEN, PASS_OFF_IDXA, PASS_OFF_CTRL};
      foreach (a[i]) begin
         rd(a[i]);
         chk(rd_q, 32'h0000_0000, "reset value");
      end
      $display("test reset done");
   endtask
   // Counts: both ways, zero, clamps, upper bits
   task automatic t_table();
      logic [31:0] cnt [10] = '{32'h0000_0008, 32'hFFFF_FFE8, 32'h0000_0000, 32'hFFFF_FF81,
         32'h0000_001F, 32'h0000_0020, 32'hFFFF_FFFF, 32'hFFFF_FFE0, 32'h0000_0028,
         32'h0000_0040};
      logic [31:0] src [10] = '{32'h00F0_0001, 32'hAE00_0000, 32'h8000_0003, 32'h4000_0001,
         32'h0000_0001, 32'h0000_0003, 32'h8000_0001, 32'h0000_0001, 32'hFFFF_FFFF,
         32'h8000_0000};
      logic [33:0] r;
      logic [6:0]  f0;
      apb(PASS_OFF_OPER, 32'h0000_0501);
      apb(PASS_OFF_SBASE, 32'h10);
      apb(PASS_OFF_DBASE, 32'h20);
      foreach (cnt[i]) begin
         f0 = i[0] ? 7'h7F : 7'h00;
         apb(PASS_OFF_FLAGS, {25'h0, f0});
         apb(12'h044, cnt[i]);
         apb(12'h054, 32'h5A5A_0000 + i);
         apb(12'h440, src[i]);
         apb(PASS_OFF_ICLR, 32'h7);
         apb(PASS_OFF_CTRL, {30'h0, i[0], 1'b1});
         r = ref_sh(src[i], cnt[i][6:0]);
         rd(12'h040);
         chk(rd_q, r[31:0], "shift result");
         rd(PASS_OFF_FLAGS);
         chk(rd_q, {25'h0, f0[6], f0[5] | r[33], 1'b0, r[31], r[31:0] == 0, r[33], r[32]},
             "flags");
         rd(12'h480);
         chk(rd_q, 32'h5A5A_0000 + i, "stored word");
         rd(PASS_OFF_ISTAT);
         chk({30'h0, rd_q[1:0]}, {30'h0, r[33], 1'b1}, "status");
      end
      $display("test table done");
   endtask
   // Shift overwrites the store's source register; store overwrites the shift's source word
   task automatic t_par();
      apb(12'h044, 32'h4);
      apb(12'h054, 32'h35);
      apb(PASS_OFF_IDXA, 32'h08);
      apb(PASS_OFF_IDXB, 32'hF8);
      apb(12'h460, 32'h1234_5678);
      apb(PASS_OFF_OPER, 32'h0000_E551);
      apb(PASS_OFF_CTRL, 32'h1);
      rd(12'h054);
      chk(rd_q, 32'h2345_6780, "shift into store source");
      rd(12'h460);
      chk(rd_q, 32'h0000_0035, "shared word");
      $display("test parallel done");
   endtask
   task automatic t_disp();
      logic [7:0] off [4] = '{8'h0, 8'h1, 8'h5, 8'h9};
      apb(PASS_OFF_IDXA, 32'h5);
      apb(PASS_OFF_IDXB, 32'h9);
      apb(PASS_OFF_SBASE, 32'h30);
      apb(PASS_OFF_DBASE, 32'h50);
      apb(12'h044, 32'h0);
      foreach (off[d]) begin
         apb(12'h400 + 12'(4 * (8'h30 + off[d])), 32'hC0DE_0000 + d);
         apb(12'h048, 32'h00D0_0000 + d);
         apb(PASS_OFF_OPER, (d << 14) | (d << 12) | 32'h0201);
         apb(PASS_OFF_CTRL, 32'h1);
         rd(12'h040);
         chk(rd_q, 32'hC0DE_0000 + d, "unshifted source");
         rd(PASS_OFF_FLAGS);
         chk({31'h0, rd_q[PASS_F_C]}, 32'h0, "carry at zero count");
         rd(12'h400 + 12'(4 * (8'h50 + off[d])));
         chk(rd_q, 32'h00D0_0000 + d, "displaced store");
      end
      $display("test displacement done");
   endtask
   // Register 8 refused; only status moves
   task automatic t_ill();
      logic [31:0] f;
      rd(PASS_OFF_FLAGS);
      f = rd_q;
      apb(12'h040, 32'h1111_2222);
      apb(PASS_OFF_OPER, 32'h0000_0508);
      apb(PASS_OFF_IEN, 32'h4);
      apb(PASS_OFF_ICLR, 32'h7);
      apb(PASS_OFF_CTRL, 32'h1);
      rd(PASS_OFF_ISTAT);
      chk(rd_q, 32'h4, "refused status");
      chk_irq(1'b1);
      rd(12'h040);
      chk(rd_q, 32'h1111_2222, "refused destination");
      rd(PASS_OFF_FLAGS);
      chk(rd_q, f, "refused flags");
      apb(PASS_OFF_ICLR, 32'h4);
      chk_irq(1'b0);
      $display("test refusal done");
   endtask
   task automatic t_irq();
      apb(PASS_OFF_OPER, 32'h0000_0501);
      apb(PASS_OFF_IEN, 32'h1);
      apb(PASS_OFF_CTRL, 32'h1);
      chk_irq(1'b1);
      apb(PASS_OFF_IEN, 32'h0);
      chk_irq(1'b0);
      apb(PASS_OFF_IEN, 32'h1);
      chk_irq(1'b1);
      apb(PASS_OFF_ICLR, 32'h1);
      chk_irq(1'b0);
      rd(PASS_OFF_ISTAT);
      chk(rd_q, 32'h0, "cleared status");
      $display("test interrupt done");
   endtask
   task automatic t_unmap();
      rd(12'h028);
      chk({rd_e, rd_q[30:0]}, 32'h8000_0000, "gap read");
      apb(12'h800, 32'hFFFF_FFFF);
      chk({31'h0, rd_e}, 32'h1, "outside window");
      rd(PASS_OFF_ICLR);
      chk({rd_e, rd_q[30:0]}, 32'h0, "clear reads zero");
      $display("test unmapped done");
   endtask
   // Reset for 20 cycles, then each scenario
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_table();
      t_par();
      t_disp();
      t_ill();
      t_irq();
      t_unmap();
      give_verdict();
   end
endmodule
